// >>> src/pwm_controller.sv
// What this block does
// - each divider divides its chosen prescaled clock
// - reset clears divider factors and prescale selects
// - prescaled clocks except undivided held off at reset
// - four channels: selector, 16-bit counter, comparator
// - clock select picks eleven prescales or A/B
// - left-aligned counts up to period minus one, then restarts
// - center-aligned counts up then down, double period
// - period equals prescale factor times period value
// - duty sets counts spent at starting level
// - polarity sets starting level, default low
// - alignment bit selects mode, default left-aligned
// - output fixed low at duty/polarity extremes
// - output fixed high at opposite extremes
// - polarity takes effect only while channel disabled
// - direct period/duty writes only while disabled
// - bits in one enable write start together
// - update value held until period end
// - update target bit picks period or duty
// - period end sets flag; flags register read clears
// - enable-set unmasks, disable-set masks channel interrupt
// - factor zero stops, one passes, else divides
`timescale 1ns/1ps
`default_nettype none
module pwm_controller #(
  parameter int NUM_CH = pwm_pkg::NUM_CH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // waveform pins and interrupt
  output logic [NUM_CH-1:0] waveform_output_o,
  output logic irq_o
);

  localparam int CW = pwm_pkg::CNT_W;
  localparam logic [CW-1:0] CNT_ZERO = pwm_pkg::CNT_RST;

  // bus handshake
  logic ack;
  logic do_wr;
  logic do_rd;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic ch_win;
  logic [1:0] ch_idx;
  logic [4:0] ch_reg;
  logic [31:0] rd_mux;

  // clock generator
  logic [pwm_pkg::PRE_CNT_W-1:0] pre_cnt;
  logic [pwm_pkg::NUM_PRE-1:0] pre_tick;
  pwm_pkg::divider_cfg_t cfg_a;
  pwm_pkg::divider_cfg_t cfg_b;
  logic divided_clock_a;
  logic divided_clock_b;

  // channel state
  pwm_pkg::chan_mode_t chan_mode [NUM_CH];
  logic [CW-1:0] period_value [NUM_CH];
  logic [CW-1:0] duty_value [NUM_CH];
  logic [CW-1:0] chan_cnt [NUM_CH];
  logic [CW-1:0] update_value [NUM_CH];
  logic [NUM_CH-1:0] update_pending;
  logic [NUM_CH-1:0] count_down;
  logic [NUM_CH-1:0] chan_en;
  logic [NUM_CH-1:0] chan_tick;
  logic [NUM_CH-1:0] period_end;
  logic [NUM_CH-1:0] irq_mask;
  logic [NUM_CH-1:0] irq_flags;
  logic [NUM_CH-1:0] flag_clear;

  // channel clock selector, shared by every channel
  function automatic logic select_tick(input logic [3:0] sel,
                                       input logic [pwm_pkg::NUM_PRE-1:0] pre,
                                       input logic tick_a, input logic tick_b);
    logic t;
    t = 1'b0;
    if (sel < 4'(pwm_pkg::NUM_PRE))
    begin
      t = pre[sel];
    end
    else if (sel == pwm_pkg::SEL_DIVIDED_A)
    begin
      t = tick_a;
    end
    else if (sel == pwm_pkg::SEL_DIVIDED_B)
    begin
      t = tick_b;
    end
    return t;
  endfunction : select_tick

  // byte-enable merge for stored registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    return (old & ~m) | (wd & m);
  endfunction : merge

  // two-cycle access: waitrequest high in the request's first cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
    end
  end

  assign avs_waitrequest_o = ~ack;
  assign do_wr = avs_write_i & ack;
  assign do_rd = avs_read_i & ack;
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wbits = avs_writedata_i & wmask;
  assign ch_win = (avs_address_i[9:7] == pwm_pkg::CH_WINDOW_TAG);
  assign ch_idx = avs_address_i[pwm_pkg::CH_SEL_LSB +: 2];
  assign ch_reg = avs_address_i[4:0];

  // read mux; unmapped and write-only addresses read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (ch_win)
    begin
      case (ch_reg)
        pwm_pkg::OFS_CHANNEL_MODE:
        begin
          rd_mux[pwm_pkg::CLOCK_SELECT_LSB +: 4] = chan_mode[ch_idx].channel_clock_select;
          rd_mux[pwm_pkg::CENTER_ALIGN_BIT] = chan_mode[ch_idx].center_align_sel;
          rd_mux[pwm_pkg::POLARITY_BIT] = chan_mode[ch_idx].output_polarity;
          rd_mux[pwm_pkg::UPDATE_TARGET_BIT] = chan_mode[ch_idx].update_target_sel;
        end
        pwm_pkg::OFS_CHANNEL_DUTY: rd_mux[CW-1:0] = duty_value[ch_idx];
        pwm_pkg::OFS_CHANNEL_PERIOD: rd_mux[CW-1:0] = period_value[ch_idx];
        pwm_pkg::OFS_CHANNEL_COUNTER: rd_mux[CW-1:0] = chan_cnt[ch_idx];
        default: rd_mux = 32'h0000_0000;
      endcase
    end
    else
    begin
      case (avs_address_i)
        pwm_pkg::OFS_DIVIDER_CONFIG:
        begin
          rd_mux[pwm_pkg::LINEAR_DIV_A_LSB +: 8] = cfg_a.linear_div;
          rd_mux[pwm_pkg::PRESCALE_SEL_A_LSB +: 4] = cfg_a.prescale_sel;
          rd_mux[pwm_pkg::LINEAR_DIV_B_LSB +: 8] = cfg_b.linear_div;
          rd_mux[pwm_pkg::PRESCALE_SEL_B_LSB +: 4] = cfg_b.prescale_sel;
        end
        pwm_pkg::OFS_CHANNEL_STATUS: rd_mux[NUM_CH-1:0] = chan_en;
        pwm_pkg::OFS_IRQ_MASK_VIEW: rd_mux[NUM_CH-1:0] = irq_mask;
        pwm_pkg::OFS_IRQ_FLAGS_CLEAR_ON_READ: rd_mux[NUM_CH-1:0] = irq_flags;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // read data captured in the waiting cycle, stands through the accept cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      avs_readdata_o <= 32'h0000_0000;
    end
    else if (avs_read_i & ~ack)
    begin
      avs_readdata_o <= rd_mux;
    end
  end

  // free-running modulo counter; ticks above the undivided one held off in reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_cnt <= '0;
    end
    else
    begin
      pre_cnt <= pre_cnt + 1'b1;
    end
  end

  assign pre_tick[0] = 1'b1;
  for (genvar k = 1; k < pwm_pkg::NUM_PRE; k++)
  begin : g_pre
    assign pre_tick[k] = ~rst_i & (&pre_cnt[k-1:0]);
  end

  // divider configuration register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_a <= '{prescale_sel: pwm_pkg::PRESCALE_SEL_RST, linear_div: pwm_pkg::LINEAR_DIV_RST};
      cfg_b <= '{prescale_sel: pwm_pkg::PRESCALE_SEL_RST, linear_div: pwm_pkg::LINEAR_DIV_RST};
    end
    else if (do_wr && !ch_win && avs_address_i == pwm_pkg::OFS_DIVIDER_CONFIG)
    begin
      cfg_a.linear_div <= 8'(merge({24'h0, cfg_a.linear_div}, avs_writedata_i, wmask));
      cfg_a.prescale_sel <= 4'(merge({20'h0, cfg_a.prescale_sel, 8'h0}, avs_writedata_i,
                                     wmask) >> pwm_pkg::PRESCALE_SEL_A_LSB);
      cfg_b.linear_div <= 8'(merge({8'h0, cfg_b.linear_div, 16'h0}, avs_writedata_i,
                                   wmask) >> pwm_pkg::LINEAR_DIV_B_LSB);
      cfg_b.prescale_sel <= 4'(merge({4'h0, cfg_b.prescale_sel, 24'h0}, avs_writedata_i,
                                     wmask) >> pwm_pkg::PRESCALE_SEL_B_LSB);
    end
  end

  // the two linear dividers
  linear_divider u_div_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(pre_tick),
    .cfg_i(cfg_a),
    .clk_en_o(divided_clock_a)
  );

  linear_divider u_div_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(pre_tick),
    .cfg_i(cfg_b),
    .clk_en_o(divided_clock_b)
  );

  // per-channel clock enable and end-of-period detect
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    assign chan_tick[c] = chan_en[c] & select_tick(chan_mode[c].channel_clock_select,
      pre_tick, divided_clock_a, divided_clock_b);
    assign period_end[c] = chan_tick[c] & (chan_mode[c].center_align_sel
      ? (count_down[c] && chan_cnt[c] == CNT_ZERO)
      : (period_value[c] == CNT_ZERO || chan_cnt[c] >= period_value[c] - 16'h0001));
  end

  // channel enable: one write starts every named channel on the same edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chan_en <= '0;
    end
    else if (do_wr && !ch_win && avs_address_i == pwm_pkg::OFS_CHANNEL_ENABLE_SET)
    begin
      chan_en <= chan_en | wbits[NUM_CH-1:0];
    end
    else if (do_wr && !ch_win && avs_address_i == pwm_pkg::OFS_CHANNEL_DISABLE_SET)
    begin
      chan_en <= chan_en & ~wbits[NUM_CH-1:0];
    end
  end

  // channel counters; a disabled channel sits at zero, so starts line up
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (rst_i || !chan_en[i])
      begin
        chan_cnt[i] <= CNT_ZERO;
        count_down[i] <= 1'b0;
      end
      else if (chan_tick[i])
      begin
        if (!chan_mode[i].center_align_sel)
        begin
          chan_cnt[i] <= period_end[i] ? CNT_ZERO : chan_cnt[i] + 16'h0001;
        end
        else if (!count_down[i])
        begin
          if (chan_cnt[i] >= period_value[i])
          begin
            count_down[i] <= 1'b1;
            chan_cnt[i] <= (chan_cnt[i] == CNT_ZERO) ? CNT_ZERO : chan_cnt[i] - 16'h0001;
          end
          else
          begin
            chan_cnt[i] <= chan_cnt[i] + 16'h0001;
          end
        end
        else if (chan_cnt[i] == CNT_ZERO)
        begin
          count_down[i] <= 1'b0;
          chan_cnt[i] <= (period_value[i] == CNT_ZERO) ? CNT_ZERO : 16'h0001;
        end
        else
        begin
          chan_cnt[i] <= chan_cnt[i] - 16'h0001;
        end
      end
    end
  end

  // channel configuration: mode, period, duty and the double buffer
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (rst_i)
      begin
        chan_mode[i] <= '0;
        period_value[i] <= CNT_ZERO;
        duty_value[i] <= CNT_ZERO;
        update_value[i] <= CNT_ZERO;
        update_pending[i] <= 1'b0;
      end
      else
      begin
        // buffered value lands at the end of the running period
        if (period_end[i] && update_pending[i])
        begin
          update_pending[i] <= 1'b0;
          if (chan_mode[i].update_target_sel)
          begin
            duty_value[i] <= update_value[i];
          end
          else
          begin
            period_value[i] <= update_value[i];
          end
        end
        if (do_wr && ch_win && ch_idx == 2'(i))
        begin
          case (ch_reg)
            pwm_pkg::OFS_CHANNEL_MODE:
            begin
              if (avs_byteenable_i[0])
              begin
                chan_mode[i].channel_clock_select <= avs_writedata_i[pwm_pkg::CLOCK_SELECT_LSB +: 4];
              end
              if (avs_byteenable_i[1])
              begin
                chan_mode[i].update_target_sel <= avs_writedata_i[pwm_pkg::UPDATE_TARGET_BIT];
                // polarity and alignment are frozen while running
                if (!chan_en[i])
                begin
                  chan_mode[i].output_polarity <= avs_writedata_i[pwm_pkg::POLARITY_BIT];
                  chan_mode[i].center_align_sel <= avs_writedata_i[pwm_pkg::CENTER_ALIGN_BIT];
                end
              end
            end
            pwm_pkg::OFS_CHANNEL_DUTY:
            begin
              if (!chan_en[i])
              begin
                duty_value[i] <= CW'(merge({16'h0, duty_value[i]}, avs_writedata_i, wmask));
              end
            end
            pwm_pkg::OFS_CHANNEL_PERIOD:
            begin
              if (!chan_en[i])
              begin
                period_value[i] <= CW'(merge({16'h0, period_value[i]}, avs_writedata_i,
                                             wmask));
              end
            end
            pwm_pkg::OFS_CHANNEL_UPDATE:
            begin
              // a write in the transfer cycle stays pending for the next end
              update_value[i] <= CW'(merge({16'h0, update_value[i]}, avs_writedata_i,
                                           wmask));
              update_pending[i] <= 1'b1;
            end
            default:
            begin
            end
          endcase
        end
      end
    end
  end

  // comparator: starting level for duty counts, then the other level
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (rst_i)
      begin
        waveform_output_o[i] <= 1'b0;
      end
      else if (!chan_en[i])
      begin
        waveform_output_o[i] <= chan_mode[i].output_polarity;
      end
      else if (duty_value[i] == period_value[i] || chan_cnt[i] < duty_value[i])
      begin
        waveform_output_o[i] <= chan_mode[i].output_polarity;
      end
      else
      begin
        waveform_output_o[i] <= ~chan_mode[i].output_polarity;
      end
    end
  end

  // interrupt mask set and clear strobes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_mask <= '0;
    end
    else if (do_wr && !ch_win && avs_address_i == pwm_pkg::OFS_IRQ_ENABLE_SET)
    begin
      irq_mask <= irq_mask | wbits[NUM_CH-1:0];
    end
    else if (do_wr && !ch_win && avs_address_i == pwm_pkg::OFS_IRQ_DISABLE_SET)
    begin
      irq_mask <= irq_mask & ~wbits[NUM_CH-1:0];
    end
  end

  // only flags the read actually returned are cleared, so no event is lost
  assign flag_clear = (do_rd && !ch_win && avs_address_i == pwm_pkg::OFS_IRQ_FLAGS_CLEAR_ON_READ)
    ? avs_readdata_o[NUM_CH-1:0] : '0;

  // sticky end-of-period flags; set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_flags <= '0;
    end
    else
    begin
      irq_flags <= (irq_flags & ~flag_clear) | period_end;
    end
  end

  assign irq_o = |(irq_flags & irq_mask);

endmodule : pwm_controller
`default_nettype wire

// >>> include/pwm_pkg.sv
`default_nettype none
package pwm_pkg;

  // channel count and counter width
  localparam int NUM_CH = 4;
  localparam int CNT_W = 16;
  localparam int NUM_PRE = 11;
  localparam int PRE_CNT_W = 10;

  // global register byte offsets
  localparam logic [9:0] OFS_DIVIDER_CONFIG = 10'h000;
  localparam logic [9:0] OFS_CHANNEL_ENABLE_SET = 10'h004;
  localparam logic [9:0] OFS_CHANNEL_DISABLE_SET = 10'h008;
  localparam logic [9:0] OFS_CHANNEL_STATUS = 10'h00c;
  localparam logic [9:0] OFS_IRQ_ENABLE_SET = 10'h010;
  localparam logic [9:0] OFS_IRQ_DISABLE_SET = 10'h014;
  localparam logic [9:0] OFS_IRQ_MASK_VIEW = 10'h018;
  localparam logic [9:0] OFS_IRQ_FLAGS_CLEAR_ON_READ = 10'h01c;

  // channel window: base, per-channel stride bit, register offsets inside it
  localparam logic [2:0] CH_WINDOW_TAG = 3'h4;
  localparam int CH_SEL_LSB = 5;
  localparam logic [4:0] OFS_CHANNEL_MODE = 5'h00;
  localparam logic [4:0] OFS_CHANNEL_DUTY = 5'h04;
  localparam logic [4:0] OFS_CHANNEL_PERIOD = 5'h08;
  localparam logic [4:0] OFS_CHANNEL_COUNTER = 5'h0c;
  localparam logic [4:0] OFS_CHANNEL_UPDATE = 5'h10;

  // divider_config fields
  localparam int LINEAR_DIV_A_LSB = 0;
  localparam int PRESCALE_SEL_A_LSB = 8;
  localparam int LINEAR_DIV_B_LSB = 16;
  localparam int PRESCALE_SEL_B_LSB = 24;

  // channel_mode fields
  localparam int CLOCK_SELECT_LSB = 0;
  localparam int CENTER_ALIGN_BIT = 8;
  localparam int POLARITY_BIT = 9;
  localparam int UPDATE_TARGET_BIT = 10;

  // channel_clock_select codes above the prescaled set
  localparam logic [3:0] SEL_DIVIDED_A = 4'hb;
  localparam logic [3:0] SEL_DIVIDED_B = 4'hc;

  // reset values
  localparam logic [7:0] LINEAR_DIV_RST = 8'h00;
  localparam logic [3:0] PRESCALE_SEL_RST = 4'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // one divider's configuration
  typedef struct packed {
    logic [3:0] prescale_sel;
    logic [7:0] linear_div;
  } divider_cfg_t;

  // one channel's mode fields
  typedef struct packed {
    logic update_target_sel;
    logic output_polarity;
    logic center_align_sel;
    logic [3:0] channel_clock_select;
  } chan_mode_t;

endpackage : pwm_pkg
`default_nettype wire

// >>> src/linear_divider.sv
`timescale 1ns/1ps
`default_nettype none
module linear_divider (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // prescaled enables and configuration
  input wire logic [pwm_pkg::NUM_PRE-1:0] tick_i,
  input wire pwm_pkg::divider_cfg_t cfg_i,
  // divided clock enable
  output logic clk_en_o
);

  logic src_tick;
  logic [7:0] div_cnt;

  // pick the prescaled enable; reserved codes give no clock
  always_comb
  begin
    src_tick = 1'b0;
    if (cfg_i.prescale_sel < 4'(pwm_pkg::NUM_PRE))
    begin
      src_tick = tick_i[cfg_i.prescale_sel];
    end
  end

  // count source ticks up to the factor; zero stops, one passes through
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_cnt <= 8'h00;
    end
    else if (cfg_i.linear_div == 8'h00)
    begin
      div_cnt <= 8'h00;
    end
    else if (src_tick)
    begin
      div_cnt <= (div_cnt >= cfg_i.linear_div - 8'h01) ? 8'h00 : div_cnt + 8'h01;
    end
  end

  // pulse on the last source tick of each divided cycle
  assign clk_en_o = (cfg_i.linear_div != 8'h00) && src_tick
    && (div_cnt >= cfg_i.linear_div - 8'h01);

endmodule : linear_divider
`default_nettype wire

// >>> test/pwm_controller_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_controller_asserts #(
  parameter int NUM_CH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // pins
  input wire logic [NUM_CH-1:0] waveform_output_o,
  input wire logic irq_o
);
  logic [3:0] en_t;
  logic [3:0] mask_t;
  logic pol0;
  logic [1:0] settle;
  wire logic wr_ok = avs_write_i && !avs_waitrequest_o;
  wire logic rd_ok = avs_read_i && !avs_waitrequest_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // shadow of enables, mask, ch0 polarity; full byte lanes assumed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_t <= 4'h0;
      mask_t <= 4'h0;
      pol0 <= 1'b0;
    end
    else if (wr_ok)
    begin
      case (avs_address_i)
        10'h004: en_t <= en_t | avs_writedata_i[3:0];
        10'h008: en_t <= en_t & ~avs_writedata_i[3:0];
        10'h010: mask_t <= mask_t | avs_writedata_i[3:0];
        10'h014: mask_t <= mask_t & ~avs_writedata_i[3:0];
        10'h200: if (!en_t[0]) pol0 <= avs_writedata_i[9];
        default: ;
      endcase
    end
  end
  // cycles since ch0 last ran or took a mode write, saturating
  always_ff @(posedge clk_i)
  begin
    if (rst_i || en_t[0] || (wr_ok && avs_address_i == 10'h200))
      settle <= 2'h0;
    else if (settle != 2'h3)
      settle <= settle + 2'h1;
  end
  sequence pol_wr;
    wr_ok && avs_address_i == 10'h200 && !en_t[0];
  endsequence
  sequence flag_rd;
    rd_ok && avs_address_i == 10'h01c;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> waveform_output_o == '0
    && !irq_o && avs_readdata_o == 32'h0 && avs_waitrequest_o) else $error("reset state");
  a_pol_disabled: assert property (pol_wr |=> ##[0:2] waveform_output_o[0] == pol0)
    else $error("polarity not applied");
  a_idle_level: assert property (settle == 2'h3 |-> waveform_output_o[0] == pol0)
    else $error("idle level wrong");
  a_irq_masked: assert property (irq_o |-> mask_t != 4'h0) else $error("irq unmasked");
  a_mask_view: assert property (rd_ok && avs_address_i == 10'h018
    |-> avs_readdata_o[3:0] == mask_t) else $error("mask view wrong");
  a_status_view: assert property (rd_ok && avs_address_i == 10'h00c
    |-> avs_readdata_o[3:0] == en_t) else $error("status wrong");
  a_flag_report: assert property (flag_rd ##0 $past(irq_o)
    |-> (avs_readdata_o[3:0] & mask_t) != 4'h0) else $error("flag missing");
  a_irq_holds: assert property (irq_o && !(avs_read_i && avs_address_i == 10'h01c)
    && !(avs_write_i && avs_address_i == 10'h014) |=> irq_o) else $error("irq dropped");
endmodule : pwm_controller_asserts
bind pwm_controller pwm_controller_asserts #(.NUM_CH(NUM_CH)) chk (.clk_i(clk_i),
  .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .waveform_output_o(waveform_output_o),
  .irq_o(irq_o));
`default_nettype wire

// >>> test/pwm_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // observed pins
  input wire logic [3:0] wave_i,
  // running counts
  output logic [3:0][15:0] high_cnt_o,
  output logic [3:0][15:0] rise_cnt_o
);
  logic [3:0] last;
  // passive load: counts high cycles and rising edges, never drives back
  always_ff @(posedge clk_i)
  begin
    last <= wave_i;
    if (rst_i)
    begin
      high_cnt_o <= '0;
      rise_cnt_o <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        high_cnt_o[i] <= high_cnt_o[i] + 16'(wave_i[i]);
        rise_cnt_o[i] <= rise_cnt_o[i] + 16'(wave_i[i] && !last[i]);
      end
    end
  end
endmodule : pwm_load_model
`default_nettype wire

// >>> test/test_pwm_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_pwm_controller;
  logic clk_i;
  logic rst_i;
  logic [9:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [3:0] waveform_output_o;
  logic irq_o;
  logic [3:0][15:0] high_cnt;
  logic [3:0][15:0] rise_cnt;
  logic [3:0][15:0] dh;
  logic [3:0][15:0] dr;
  logic [31:0] rd;
  int miscompares;
  int checks;
  logic [9:0] zero_addr [10] = '{10'h000, 10'h00c, 10'h018, 10'h01c, 10'h200,
    10'h204, 10'h208, 10'h20c, 10'h210, 10'h100};
  logic [31:0] cfg_mode [4] = '{32'h400, 32'h001, 32'h100, 32'h00c};
  logic [31:0] cfg_per [4] = '{32'ha, 32'h5, 32'h4, 32'h4};
  logic [31:0] cfg_dut [4] = '{32'h3, 32'h1, 32'h1, 32'h2};

  pwm_controller #(.NUM_CH(4)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .waveform_output_o(waveform_output_o), .irq_o(irq_o));
  pwm_load_model load (.clk_i(clk_i), .rst_i(rst_i), .wave_i(waveform_output_o),
    .high_cnt_o(high_cnt), .rise_cnt_o(rise_cnt));

  // free-running 100 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task give_verdict();
    if (miscompares == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  // waitrequest and read data are taken at the rising edge that accepts
  task wait_ack();
    int n;
    n = 0;
    @(posedge clk_i);
    while (avs_waitrequest_o !== 1'b0)
    begin
      n++;
      if (n > 50)
      begin
        miscompares++;
        give_verdict();
      end
      @(posedge clk_i);
    end
    rd = avs_readdata_o;
  endtask : wait_ack

  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= 1'b1;
    wait_ack();
    avs_write_i <= 1'b0;
  endtask : wr

  task bus_rd(input logic [9:0] a);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_read_i <= 1'b1;
    wait_ack();
    avs_read_i <= 1'b0;
  endtask : bus_rd

  task rd_chk(input logic [9:0] a, input logic [31:0] e);
    bus_rd(a);
    check_word(rd, e);
  endtask : rd_chk

  // window of 120 cycles, a multiple of every period used here
  task measure();
    logic [3:0][15:0] h0;
    logic [3:0][15:0] r0;
    @(negedge clk_i);
    h0 = high_cnt;
    r0 = rise_cnt;
    repeat (120) @(negedge clk_i);
    dh = high_cnt - h0;
    dr = rise_cnt - r0;
  endtask : measure

  // main sequence
  initial
  begin
    rst_i = 1'b1;
    avs_address_i = 10'h000;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    miscompares = 0;
    checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (zero_addr[i]) rd_chk(zero_addr[i], 32'h0);
    check_word(32'(waveform_output_o), 32'h0);
    wr(10'h200, 32'h200);
    repeat (3) @(negedge clk_i);
    check_word(32'(waveform_output_o[0]), 32'h1);
    wr(10'h000, 32'h3);
    rd_chk(10'h000, 32'h3);
    for (int i = 0; i < 4; i++)
    begin
      wr(10'h200 + 10'(i * 32), cfg_mode[i]);
      wr(10'h208 + 10'(i * 32), cfg_per[i]);
      wr(10'h204 + 10'(i * 32), cfg_dut[i]);
    end
    wr(10'h010, 32'h1);
    rd_chk(10'h018, 32'h1);
    wr(10'h004, 32'hf);
    rd_chk(10'h00c, 32'hf);
    repeat (40) @(posedge clk_i);
    measure();
    check_word(32'(dh[0]), 32'h54);
    check_word(32'(dr[0]), 32'hc);
    check_word(32'(dh[1]), 32'h60);
    check_word(32'(dr[2]), 32'hf);
    check_word(32'(dr[3]), 32'h0);
    check_word(32'(irq_o), 32'h1);
    rd_chk(10'h01c, 32'h7);
    wr(10'h014, 32'h1);
    rd_chk(10'h018, 32'h0);
    // let channels 0 to 2 close at least one period again; channel 3 is enabled but its divided B clock is stopped
    repeat (12) @(posedge clk_i);
    rd_chk(10'h01c, 32'h7);
    repeat (20) @(negedge clk_i);
    check_word(32'(irq_o), 32'h0);
    wr(10'h208, 32'h14);
    rd_chk(10'h208, 32'ha);
    // align to a fresh period end so the pending update is seen held
    bus_rd(10'h01c);
    repeat (20)
    begin
      bus_rd(10'h01c);
      if (rd[0] === 1'b1)
        break;
    end
    check_word(32'(rd[0]), 32'h1);
    wr(10'h210, 32'h5);
    rd_chk(10'h204, 32'h3);
    repeat (12) @(posedge clk_i);
    rd_chk(10'h204, 32'h5);
    wr(10'h200, 32'h600);
    rd_chk(10'h200, 32'h400);
    measure();
    check_word(32'(dh[0]), 32'h3c);
    wr(10'h008, 32'hb);
    wr(10'h204, 32'h3);
    wr(10'h220, 32'h0);
    wr(10'h228, 32'ha);
    wr(10'h224, 32'h3);
    wr(10'h260, 32'h00b);
    wr(10'h004, 32'hb);
    repeat (50)
    begin
      @(negedge clk_i);
      check_word(32'(waveform_output_o[1]), 32'(waveform_output_o[0]));
    end
    measure();
    check_word(32'(dh[0]), 32'h54);
    check_word(32'(dr[3]), 32'ha);
    check_word(32'(dh[3]), 32'h3c);
    give_verdict();
  end
endmodule : test_pwm_controller
`default_nettype wire
